// file: hdl/qxc_counter.sv
// Overview of operation
// - A rising counts up with B low, down with B high; falling reverses.
// - B rising counts down with A low, up with A high; falling reverses.
// - Accumulator holds without phase edges or while count enable is off, unless a mode 9 zero reset zeroes it.
// - Mode 9: reset with both phases low zeroes; hold freezes the count while zero reset is low.
// - Software loads start value; accumulator tracks the live signed count.
// - Reaching the high setpoint raises an event.
// - Error when high setpoint is not below the upper rollover limit.
// - Reaching the low setpoint raises an event.
// - Modes 0 and 1: error when low setpoint is above zero.
// - Error when low setpoint is below the lower rollover limit.
// - Past upper limit: overflow event, reload lower limit, keep counting.
// - Error when upper limit is not above the high setpoint.
// - Past lower limit: underflow event, reload upper limit, keep counting.
// - Error when lower limit is above the low setpoint.
`timescale 1ns/1ps
`default_nettype none

module qxc_counter
    import qxc_pkg::*;
#(
    parameter int SYNC_STAGES = 3
) (
    input wire logic clk,
    input wire logic resetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    input wire qxc_pkg::qxc_pins_t pinsIn,
    output logic counterError
);
    import qxc_pkg::*;

    // ****************************************************************
    // Input synchroniser
    // ****************************************************************
    qxc_pins_t syncFf [SYNC_STAGES];
    qxc_pins_t pinsFf;

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            syncFf[0] <= '0;
        end else begin
            syncFf[0] <= pinsIn;
        end
    end

    // Later stages only ever read the stage before them
    for (genvar gi = 1; gi < SYNC_STAGES; gi++) begin : g_sync
        always_ff @(posedge clk or negedge resetn) begin
            if (!resetn) begin
                syncFf[gi] <= '0;
            end else begin
                syncFf[gi] <= syncFf[gi-1];
            end
        end
    end

    // Agreed level moves only when the second and third stages match
    wire logic pinsAgree = (syncFf[SYNC_STAGES-1] == syncFf[SYNC_STAGES-2]);
    wire qxc_pins_t nxt_pins = pinsAgree ? syncFf[SYNC_STAGES-1] : pinsFf;

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            pinsFf <= '0;
        end else begin
            pinsFf <= nxt_pins;
        end
    end

    // ****************************************************************
    // Edge detection
    // ****************************************************************
    wire logic riseA = nxt_pins.phaseA & ~pinsFf.phaseA;
    wire logic fallA = ~nxt_pins.phaseA & pinsFf.phaseA;
    wire logic riseB = nxt_pins.phaseB & ~pinsFf.phaseB;
    wire logic fallB = ~nxt_pins.phaseB & pinsFf.phaseB;

    // ****************************************************************
    // Registers
    // ****************************************************************
    logic [31:0] accumFf, highSpFf, lowSpFf, upLimFf, loLimFf;
    logic countEnFf;
    logic [3:0] modeFf;
    logic errFf, highFf, lowFf, ovfFf, unfFf, dirFf;

    // ****************************************************************
    // Quadrature decode
    // ****************************************************************
    // Both phases change together: contributions cancel out (illegal step)
    wire logic upA = (riseA & ~nxt_pins.phaseB) | (fallA & nxt_pins.phaseB);
    wire logic dnA = (riseA & nxt_pins.phaseB) | (fallA & ~nxt_pins.phaseB);
    wire logic upB = (riseB & nxt_pins.phaseA) | (fallB & ~nxt_pins.phaseA);
    wire logic dnB = (riseB & ~nxt_pins.phaseA) | (fallB & nxt_pins.phaseA);
    wire logic stepUp = (upA | upB) & ~(dnA | dnB);
    wire logic stepDn = (dnA | dnB) & ~(upA | upB);

    wire logic extMode = (modeFf == MODE_QX4_RH);
    wire logic zeroReq = extMode & nxt_pins.zeroReset
                         & ~nxt_pins.phaseA & ~nxt_pins.phaseB;
    wire logic holdReq = extMode & ~nxt_pins.zeroReset & nxt_pins.holdIn;
    wire logic doUp = countEnFf & stepUp & ~holdReq;
    wire logic doDn = countEnFf & stepDn & ~holdReq;

    // ****************************************************************
    // Rollover and setpoint events
    // ****************************************************************
    wire logic atUpLim = ($signed(accumFf) >= $signed(upLimFf));
    wire logic atLoLim = ($signed(accumFf) <= $signed(loLimFf));
    wire logic evOvf = doUp & atUpLim;
    wire logic evUnf = doDn & atLoLim;

    // ****************************************************************
    // Next accumulator value
    // ****************************************************************
    // Zero reset outranks rollover, which outranks a plain step
    logic [31:0] nxt_count;
    always_comb begin
        nxt_count = accumFf;
        if (zeroReq) begin
            nxt_count = RST_ZERO;
        end else if (evOvf) begin
            nxt_count = loLimFf;
        end else if (evUnf) begin
            nxt_count = upLimFf;
        end else if (doUp) begin
            nxt_count = accumFf + 32'h0000_0001;
        end else if (doDn) begin
            nxt_count = accumFf - 32'h0000_0001;
        end
    end

    wire logic moved = (nxt_count != accumFf);
    wire logic evHigh = moved & (nxt_count == highSpFf);
    wire logic evLow = moved & (nxt_count == lowSpFf);

    // ****************************************************************
    // Setting checks
    // ****************************************************************
    wire logic errHigh = ~($signed(highSpFf) < $signed(upLimFf));
    wire logic errLowPos = ((modeFf == MODE_ZERO) | (modeFf == MODE_ONE))
                           & ($signed(lowSpFf) > $signed(RST_ZERO));
    wire logic errLowUf = ($signed(lowSpFf) < $signed(loLimFf));
    wire logic errUp = ~($signed(upLimFf) > $signed(highSpFf));
    wire logic errLo = ($signed(loLimFf) > $signed(lowSpFf));
    wire logic errNow = errHigh | errLowPos | errLowUf | errUp | errLo;

    // ****************************************************************
    // AHB-Lite slave
    // ****************************************************************
    logic wrPendFf;
    logic [7:0] wrAddrFf;
    wire logic take = hsel & hready & (htrans == HTRANS_NONSEQ);
    wire logic wrAcc = wrPendFf & (wrAddrFf == OFS_ACCUM);
    wire logic wrHigh = wrPendFf & (wrAddrFf == OFS_HIGHSP);
    wire logic wrLow = wrPendFf & (wrAddrFf == OFS_LOWSP);
    wire logic wrUp = wrPendFf & (wrAddrFf == OFS_UPLIM);
    wire logic wrLo = wrPendFf & (wrAddrFf == OFS_LOLIM);
    wire logic wrCtrl = wrPendFf & (wrAddrFf == OFS_CTRL);
    wire logic wrStat = wrPendFf & (wrAddrFf == OFS_STATUS);

    wire qxc_evt_t ev = '{highHit: evHigh, lowHit: evLow, overflow: evOvf, underflow: evUnf};

    // Set beats clear for sticky flags
    function automatic logic sticky(input logic cur, input logic set, input logic clr);
        return set | (cur & ~clr);
    endfunction

    // ****************************************************************
    // Read path
    // ****************************************************************
    wire logic [31:0] statusWord = {26'h0, dirFf, unfFf, ovfFf, lowFf, highFf, errFf};
    wire logic [31:0] ctrlWord = {24'h0, modeFf, 3'h0, countEnFf};
    logic [31:0] nxt_rdata;
    always_comb begin
        case (haddr[7:0])
            OFS_ACCUM: nxt_rdata = accumFf;
            OFS_HIGHSP: nxt_rdata = highSpFf;
            OFS_LOWSP: nxt_rdata = lowSpFf;
            OFS_UPLIM: nxt_rdata = upLimFf;
            OFS_LOLIM: nxt_rdata = loLimFf;
            OFS_CTRL: nxt_rdata = ctrlWord;
            OFS_STATUS: nxt_rdata = statusWord;
            default: nxt_rdata = RST_ZERO;
        endcase
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            wrPendFf <= 1'b0;
            wrAddrFf <= OFS_ACCUM;
        end else begin
            wrPendFf <= take & hwrite;
            wrAddrFf <= haddr[7:0];
        end
    end

    // Read data stands from the data phase until the next read
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            hrdata <= RST_ZERO;
        end else if (take & ~hwrite) begin
            hrdata <= nxt_rdata;
        end
    end

    assign hreadyout = 1'b1;
    assign hresp = 1'b0;

    // ****************************************************************
    // Accumulator
    // ****************************************************************
    // Software load of the start value wins over a count that cycle
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            accumFf <= RST_ZERO;
        end else begin
            accumFf <= wrAcc ? hwdata : nxt_count;
        end
    end

    // ****************************************************************
    // Setpoints and rollover limits
    // ****************************************************************
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            highSpFf <= RST_HIGHSP;
        end else if (wrHigh) begin
            highSpFf <= hwdata;
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            lowSpFf <= RST_LOWSP;
        end else if (wrLow) begin
            lowSpFf <= hwdata;
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            upLimFf <= RST_UPLIM;
        end else if (wrUp) begin
            upLimFf <= hwdata;
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            loLimFf <= RST_LOLIM;
        end else if (wrLo) begin
            loLimFf <= hwdata;
        end
    end

    // ****************************************************************
    // Control register
    // ****************************************************************
    // Mode and enable take effect from the cycle after the write
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            countEnFf <= 1'b0;
        end else if (wrCtrl) begin
            countEnFf <= hwdata[CTRL_CE_BIT];
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            modeFf <= RST_MODE;
        end else if (wrCtrl) begin
            modeFf <= hwdata[CTRL_MODE_LSB +: CTRL_MODE_W];
        end
    end

    // ****************************************************************
    // Status flags
    // ****************************************************************
    // Error flag re-arms every cycle while a setting check fails
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            errFf <= 1'b0;
        end else begin
            errFf <= sticky(errFf, errNow, wrStat & hwdata[ST_ERR_BIT]);
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            highFf <= 1'b0;
        end else begin
            highFf <= sticky(highFf, ev.highHit, wrStat & hwdata[ST_HIGH_BIT]);
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            lowFf <= 1'b0;
        end else begin
            lowFf <= sticky(lowFf, ev.lowHit, wrStat & hwdata[ST_LOW_BIT]);
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            ovfFf <= 1'b0;
        end else begin
            ovfFf <= sticky(ovfFf, ev.overflow, wrStat & hwdata[ST_OVF_BIT]);
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            unfFf <= 1'b0;
        end else begin
            unfFf <= sticky(unfFf, ev.underflow, wrStat & hwdata[ST_UNF_BIT]);
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            dirFf <= 1'b0;
        end else if (doUp) begin
            dirFf <= 1'b1;
        end else if (doDn) begin
            dirFf <= 1'b0;
        end
    end

    assign counterError = errFf;

endmodule // qxc_counter
`default_nettype wire

// file: include/qxc_pkg.sv
package qxc_pkg;

    localparam int DATA_W = 32;

    // Register byte offsets
    localparam logic [7:0] OFS_ACCUM = 8'h00;
    localparam logic [7:0] OFS_HIGHSP = 8'h04;
    localparam logic [7:0] OFS_LOWSP = 8'h08;
    localparam logic [7:0] OFS_UPLIM = 8'h0C;
    localparam logic [7:0] OFS_LOLIM = 8'h10;
    localparam logic [7:0] OFS_CTRL = 8'h14;
    localparam logic [7:0] OFS_STATUS = 8'h18;

    // Control register fields
    localparam int CTRL_CE_BIT = 0;
    localparam int CTRL_MODE_LSB = 4;
    localparam int CTRL_MODE_W = 4;

    // Status register fields (write one to clear events)
    localparam int ST_ERR_BIT = 0;
    localparam int ST_HIGH_BIT = 1;
    localparam int ST_LOW_BIT = 2;
    localparam int ST_OVF_BIT = 3;
    localparam int ST_UNF_BIT = 4;
    localparam int ST_DIR_BIT = 5;

    // Counter mode selections
    localparam logic [3:0] MODE_QX4 = 4'h8;
    localparam logic [3:0] MODE_QX4_RH = 4'h9;
    localparam logic [3:0] MODE_ZERO = 4'h0;
    localparam logic [3:0] MODE_ONE = 4'h1;

    // Reset values
    localparam logic [31:0] RST_ZERO = 32'h0000_0000;
    localparam logic [31:0] RST_UPLIM = 32'h7FFF_FFFF;
    localparam logic [31:0] RST_LOLIM = 32'h8000_0000;
    localparam logic [31:0] RST_HIGHSP = 32'h7FFF_FFFE;
    localparam logic [31:0] RST_LOWSP = 32'h8000_0000;
    localparam logic [3:0] RST_MODE = 4'h8;

    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
    localparam logic [2:0] HSIZE_WORD = 3'h2;

    // Encoder pins as sampled
    typedef struct packed {
        logic phaseA;
        logic phaseB;
        logic zeroReset;
        logic holdIn;
    } qxc_pins_t;

    // Events of one cycle
    typedef struct packed {
        logic highHit;
        logic lowHit;
        logic overflow;
        logic underflow;
    } qxc_evt_t;

endpackage

// file: sim/qxc_counter_sva.sv
`timescale 1ns/1ps
`default_nettype none
module qxc_counter_chk
    import qxc_pkg::*;
(
    input wire logic clk,
    input wire logic resetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    input wire logic [31:0] hrdata,
    input wire logic hreadyout,
    input wire logic hresp,
    input wire qxc_pkg::qxc_pins_t pinsIn,
    input wire logic counterError
);
    // ****************
    // Bus and error flag
    // ****************
    logic wp_ff;
    logic [7:0] wa_ff;
    wire take = hsel && hready && htrans == HTRANS_NONSEQ;
    wire rdTake = take && !hwrite;
    wire errClr = wp_ff && wa_ff == OFS_STATUS && hwdata[ST_ERR_BIT];
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            wp_ff <= 1'b0;
        end else begin
            wp_ff <= take && hwrite;
        end
    end
    always_ff @(posedge clk) begin
        wa_ff <= haddr[7:0];
    end
    default clocking @(posedge clk); endclocking
    default disable iff (!resetn);
    ready_hi_a: assert property (hreadyout) else $error("hreadyout low");
    resp_okay_a: assert property (!hresp) else $error("hresp not okay");
    rd_hold_a: assert property (!rdTake |=> $stable(hrdata)) else $error("hrdata moved");
    unmapped_zero_a: assert property (rdTake && haddr[7:0] > OFS_STATUS |=> hrdata == 32'h0)
        else $error("unmapped read not zero");
    err_sticky_a: assert property ($fell(counterError) |-> $past(errClr))
        else $error("error flag dropped without clear");
    err_cause_a: assert property ($rose(counterError) |->
        $past(wp_ff) || $past(wp_ff, 2) || $past(wp_ff, 3))
        else $error("error flag rose without a write");
    rst_clean_a: assert property ($rose(resetn) |-> !counterError)
        else $error("error flag set after reset");
    st_bit_a: assert property (rdTake && haddr[7:0] == OFS_STATUS |=>
        hrdata[ST_ERR_BIT] == $past(counterError))
        else $error("status bit differs from flag");
    cover property (rdTake && haddr[7:0] == OFS_ACCUM);
    cover property ($rose(counterError));
    cover property ($fell(counterError));
endmodule // qxc_counter_chk
bind qxc_counter qxc_counter_chk u_chk (.clk(clk), .resetn(resetn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .pinsIn(pinsIn), .counterError(counterError));
`default_nettype wire

// file: sim/qxc_counter_tb.sv
`timescale 1ns/1ps
`default_nettype none
module qxc_counter_tb;
    import qxc_pkg::*;
    typedef struct {logic [31:0] v; logic [31:0] m;} qxc_note_t;
    logic clk = 1'b0;
    logic resetn = 1'b0;
    logic hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [31:0] hwdata = 32'h0;
    logic [31:0] hrdata;
    logic hreadyout;
    logic hresp;
    logic counterError;
    logic stepReq = 1'b0;
    logic stepUp = 1'b0;
    logic zeroReq = 1'b0;
    logic holdReq = 1'b0;
    logic rdPend = 1'b0;
    qxc_pins_t pins;
    qxc_note_t q[$];
    qxc_note_t nt;
    int n_fail = 0;
    int n_checks = 0;
    int cyc = 0;
    int expAcc;
    int upLim;
    int loLim;
    logic [7:0] ea[6] = '{OFS_HIGHSP, OFS_UPLIM, OFS_LOWSP, OFS_LOLIM, OFS_CTRL, OFS_CTRL};
    logic [31:0] eb[6] = '{32'h5, 32'h4, 32'hFFFF_FFFA, 32'hFFFF_FFFD, 32'h01, 32'h11};
    logic [31:0] eg[6] = '{32'h4, 32'h5, 32'hFFFF_FFFC, 32'hFFFF_FFFB, 32'h81, 32'h81};
    always #2 clk = ~clk;
    qxc_counter dut (.clk(clk), .resetn(resetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(HSIZE_WORD), .hwdata(hwdata),
        .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
        .pinsIn(pins), .counterError(counterError));
    qxc_enc_model enc (.clk(clk), .resetn(resetn), .stepReq(stepReq), .stepUp(stepUp),
        .zeroReq(zeroReq), .holdReq(holdReq), .pins(pins));
    // ****************
    // Checking and bus
    // ****************
    task chk(input logic [31:0] s, input logic [31:0] e);
        n_checks++;
        if (s !== e) begin
            n_fail++;
            $display("MISMATCH t=%0t seen %h expected %h", $time, s, e);
        end
    endtask
    task wrap_up;
        $display("checks %0d mismatches %0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    task bus(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [31:0] m);
        hsel <= 1'b1;
        htrans <= HTRANS_NONSEQ;
        haddr <= {24'h0, a};
        hwrite <= w;
        if (!w) q.push_back('{d, m});
        do @(posedge clk); while (!hreadyout);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge clk); while (!hreadyout);
    endtask
    task step(input logic up, input bit cnt);
        stepReq <= 1'b1;
        stepUp <= up;
        @(posedge clk);
        stepReq <= 1'b0;
        if (cnt) expAcc = up ? (expAcc >= upLim ? loLim : expAcc + 1)
                             : (expAcc <= loLim ? upLim : expAcc - 1);
        repeat (7) @(posedge clk);
    endtask
    always @(posedge clk) begin
        if (rdPend) begin
            nt = q.pop_front();
            chk(hrdata & nt.m, nt.v & nt.m);
        end
        rdPend <= hsel && htrans == HTRANS_NONSEQ && !hwrite && hreadyout;
        cyc++;
        if (cyc > 20000) begin
            n_fail++;
            wrap_up();
        end
    end
    initial begin
        void'($urandom(82005));
        repeat (4) @(posedge clk);
        resetn <= 1'b1;
        @(posedge clk);
        bus(0, OFS_ACCUM, RST_ZERO, 32'hFFFF_FFFF);
        bus(0, OFS_HIGHSP, RST_HIGHSP, 32'hFFFF_FFFF);
        bus(0, OFS_LOWSP, RST_LOWSP, 32'hFFFF_FFFF);
        bus(0, OFS_UPLIM, RST_UPLIM, 32'hFFFF_FFFF);
        bus(0, OFS_LOLIM, RST_LOLIM, 32'hFFFF_FFFF);
        bus(0, OFS_CTRL, {24'h0, RST_MODE, 4'h0}, 32'hF1);
        bus(0, 8'h1C, 32'h0, 32'hFFFF_FFFF);
        // Order keeps every intermediate setting legal, so no error is latched
        for (int i = 0; i < 4; i++) bus(1, ea[i], eg[i], 32'h0);
        loLim = 32'hFFFF_FFFB;
        upLim = 5;
        bus(1, OFS_ACCUM, 32'h2, 32'h0);
        expAcc = 2;
        bus(1, OFS_CTRL, 32'h81, 32'h0);
        repeat (4) step(1, 1);
        bus(0, OFS_ACCUM, expAcc, 32'hFFFF_FFFF);
        bus(0, OFS_STATUS, 32'h2A, 32'h3F);
        bus(1, OFS_STATUS, 32'h1F, 32'h0);
        repeat (2) step(1, 1);
        repeat (3) step(0, 1);
        bus(0, OFS_ACCUM, expAcc, 32'hFFFF_FFFF);
        bus(0, OFS_STATUS, 32'h14, 32'h3F);
        bus(1, OFS_CTRL, 32'h80, 32'h0);
        repeat (4) step(1, 0);
        bus(0, OFS_ACCUM, expAcc, 32'hFFFF_FFFF);
        bus(1, OFS_CTRL, 32'h81, 32'h0);
        repeat (30) step(1'($urandom_range(1, 0)), 1);
        bus(0, OFS_ACCUM, expAcc, 32'hFFFF_FFFF);
        bus(1, OFS_CTRL, 32'h91, 32'h0);
        while (pins.phaseA || pins.phaseB) step(1, 1);
        holdReq <= 1'b1;
        repeat (4) @(posedge clk);
        // A full phase cycle leaves both phases low for the zero reset
        repeat (4) step(1, 0);
        bus(0, OFS_ACCUM, expAcc, 32'hFFFF_FFFF);
        holdReq <= 1'b0;
        zeroReq <= 1'b1;
        repeat (8) @(posedge clk);
        zeroReq <= 1'b0;
        bus(0, OFS_ACCUM, 32'h0, 32'hFFFF_FFFF);
        bus(1, OFS_CTRL, 32'h81, 32'h0);
        for (int i = 0; i < 6; i++) begin
            if (i == 4) bus(1, OFS_LOWSP, 32'h1, 32'h0);
            if (i == 4) chk(counterError, 1'b0);
            bus(1, ea[i], eb[i], 32'h0);
            repeat (6) @(posedge clk);
            chk(counterError, 1'b1);
            bus(1, ea[i], eg[i], 32'h0);
            bus(1, OFS_STATUS, 32'h1, 32'h0);
            repeat (6) @(posedge clk);
            chk(counterError, 1'b0);
        end
        wrap_up();
    end
endmodule // qxc_counter_tb
`default_nettype wire

// file: sim/qxc_enc_model.sv
`timescale 1ns/1ps
`default_nettype none
module qxc_enc_model
    import qxc_pkg::*;
(
    input wire logic clk,
    input wire logic resetn,
    input wire logic stepReq,
    input wire logic stepUp,
    input wire logic zeroReq,
    input wire logic holdReq,
    output qxc_pkg::qxc_pins_t pins
);
    // ****************
    // Quadrature phase
    // ****************
    logic [1:0] ph_ff;
    wire [1:0] nxt_ph = stepUp ? ph_ff + 2'h1 : ph_ff - 2'h1;
    // Phase A leads B when stepping up
    assign pins = {^ph_ff, ph_ff[1], zeroReq, holdReq};
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            ph_ff <= 2'h0;
        end else if (stepReq) begin
            ph_ff <= nxt_ph;
        end
    end
endmodule // qxc_enc_model
`default_nettype wire
